// File: include/disk_cmd_pkg.sv
// What this block does
// - Commands arrive as frames at 19,200 baud
// - Frame-detectable faults get negative acknowledge, except a bad command checksum, which is silently abandoned
// - Disk faults: acknowledge, take data, then Error
// - Bad data checksum: NAK or silent abandon
// - Status ignores parameters, returns four bytes
// - Status byte zero holds drive flag bits
// - Status byte one is inverted controller status
// - Byte two format timeout, byte three zero
// - Read always returns sector data, even on error
// - Single density sectors above 720 rejected, and sector 0 unless enabled
// - Put takes data after acknowledge, no readback
// - Write is put plus verify readback
// - Format writes 40 zero-filled tracks, verifies
// - Format returns bad sector list, FFFF ends
// - Sectors addressed by a 16-bit number
// - Double density 256-byte frames, boot sectors 128
package disk_cmd_pkg;

   // Serial timing
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned BAUD_LOW = 19_200;
   localparam int unsigned BIT_CYCLES = (CLK_HZ + BAUD_LOW - 1) / BAUD_LOW;
   localparam int unsigned TX_BYTE_CYCLES = 10 * BIT_CYCLES;

   // Command and response codes
   localparam logic [7:0] CMD_STATUS = 8'h53;
   localparam logic [7:0] CMD_READ = 8'h52;
   localparam logic [7:0] CMD_PUT = 8'h50;
   localparam logic [7:0] CMD_WRITE = 8'h57;
   localparam logic [7:0] CMD_FORMAT = 8'h21;
   localparam logic [7:0] RSP_ACK = 8'h41;
   localparam logic [7:0] RSP_NAK = 8'h4E;
   localparam logic [7:0] RSP_COMPLETE = 8'h43;
   localparam logic [7:0] RSP_ERROR = 8'h45;
   localparam logic [7:0] FILL_FF = 8'hFF;
   // Drive bus address; value is arbitrary
   localparam logic [7:0] DEVICE_ID_RST = 8'h31;

   // Sector geometry
   localparam logic [15:0] SD_MAX_SECTOR = 16'h02D0;
   localparam logic [15:0] BOOT_LAST = 16'h0003;
   localparam logic [8:0] LEN_SD = 9'h080;
   localparam logic [8:0] LEN_DD = 9'h100;
   localparam logic [8:0] LEN_STATUS = 9'h004;
   localparam logic [5:0] FORMAT_TRACKS = 6'h28;

   // Register offsets, fields, reset values
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FMT_TMO = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_INFO = 8'h10;
   localparam int unsigned CTRL_DD_BIT = 0;
   localparam int unsigned CTRL_ZERO_OK_BIT = 1;
   localparam int unsigned CTRL_NAK_DATA_BIT = 2;
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [7:0] FMT_TMO_RST = 8'hE0;
   localparam int unsigned IRQ_DONE = 0;
   localparam int unsigned IRQ_ERROR = 1;
   localparam int unsigned IRQ_NAK = 2;
   localparam int unsigned IRQ_ABANDON = 3;
   localparam int unsigned INFO_BUSY_BIT = 8;

   // Status byte zero bit positions
   localparam int unsigned ST0_MOTOR = 4;
   localparam int unsigned ST0_WP = 3;
   localparam int unsigned ST0_PUT = 2;
   localparam int unsigned ST0_DATA = 1;
   localparam int unsigned ST0_CMD = 0;

   typedef enum logic [1:0] {MOP_READ, MOP_PUT, MOP_VERIFY, MOP_FORMAT} mech_op_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } byte_t;

   typedef struct packed {
      logic start;
      mech_op_t op;
      logic [15:0] sector;
      logic [5:0] tracks;
   } mech_req_t;

   typedef struct packed {
      logic done;
      logic error;
      logic wp_fail;
      logic motor;
      logic [7:0] ctl_status;
      logic bad_valid;
      logic [15:0] bad_sector;
   } mech_rsp_t;

   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } buf_port_t;

endpackage

// File: design/sector_buffer.sv
`timescale 1ns/1ps
module sector_buffer (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   // Write port
   input wire logic we_i,
   input wire logic [7:0] waddr_i,
   input wire logic [7:0] wdata_i,
   // Read port, data one cycle after address
   input wire logic [7:0] raddr_i,
   output logic [7:0] rdata_o
);
   typedef struct packed {
      logic [255:0][7:0] mem;
      logic [7:0] rdata;
   } buf_state_t;

   buf_state_t q;
   buf_state_t d;

   always_comb begin
      d = q;
      d.rdata = q.mem[raddr_i];
      if (we_i) begin
         d.mem[waddr_i] = wdata_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q <= '0;
      end else if (ce_i) begin
         q <= d;
      end
   end

   assign rdata_o = q.rdata;
endmodule

// File: design/disk_cmd_handler.sv
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module disk_cmd_handler #(
   parameter logic [7:0] DEVICE_ID = disk_cmd_pkg::DEVICE_ID_RST,
   parameter int unsigned TX_BYTE_CYCLES = disk_cmd_pkg::TX_BYTE_CYCLES
) (
   // Clock, reset, enable
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   // Host byte link
   input wire logic cmd_line_i,
   input disk_cmd_pkg::byte_t rx_i,
   output disk_cmd_pkg::byte_t tx_o,
   input wire logic tx_ready_i,
   // Mechanism side
   output disk_cmd_pkg::mech_req_t mech_req_o,
   input disk_cmd_pkg::mech_rsp_t mech_rsp_i,
   input disk_cmd_pkg::buf_port_t mech_buf_i,
   output logic [7:0] mech_buf_rdata_o,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   output logic irq_o
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_CHECK, ST_SEND_ACK, ST_SEND_NAK, ST_RX_DATA, ST_DATA_ACK,
      ST_MECH, ST_FMT_TERM, ST_SEND_FINAL, ST_SEND_DATA, ST_SEND_SUM
   } state_t;

   typedef struct packed {
      state_t st;
      logic [4:0][7:0] frm;
      logic [8:0] cnt;
      logic [8:0] len;
      logic [7:0] sum;
      logic [13:0] gap;
      logic err;
      logic [3:0] flags;
      logic [7:0] ctl;
      logic [2:0] ctrl;
      logic [7:0] fmt_tmo;
      logic [3:0] irq_st;
      logic [3:0] irq_mask;
      logic [31:0] rdata;
      logic [8:0] bptr;
      logic bpend;
      logic [7:0] bhi;
      logic start;
   } core_t;

   core_t q;
   core_t d;

   function automatic logic [7:0] chk_add(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[7:0] + {7'h00, s[8]};
   endfunction

   logic [15:0] sec;
   logic is_stat;
   logic is_read;
   logic is_put;
   logic is_write;
   logic is_fmt;
   logic dd;
   logic sec_ok;
   logic known;
   logic [8:0] sect_len;
   logic [8:0] fmt_len;
   logic [7:0] stat_byte;
   logic [7:0] tx_byte;
   logic tx_send;
   logic tx_valid;
   logic tx_fire;
   logic [7:0] mem_rdata;
   logic [7:0] mem_raddr;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic [3:0] ev;

   // Frame bytes: 0 device, 1 command, 2 low parameter, 3 high parameter, 4 checksum
   assign sec = {q.frm[3], q.frm[2]};
   assign is_stat = q.frm[1] == disk_cmd_pkg::CMD_STATUS;
   assign is_read = q.frm[1] == disk_cmd_pkg::CMD_READ;
   assign is_put = q.frm[1] == disk_cmd_pkg::CMD_PUT;
   assign is_write = q.frm[1] == disk_cmd_pkg::CMD_WRITE;
   assign is_fmt = q.frm[1] == disk_cmd_pkg::CMD_FORMAT;
   assign known = is_stat | is_read | is_put | is_write | is_fmt;
   assign dd = q.ctrl[disk_cmd_pkg::CTRL_DD_BIT];
   // Sector zero allowed only when configured; single density capped
   assign sec_ok = (sec != 16'h0000 || q.ctrl[disk_cmd_pkg::CTRL_ZERO_OK_BIT]) &&
                   (dd || sec <= disk_cmd_pkg::SD_MAX_SECTOR);
   assign sect_len = (dd && sec > disk_cmd_pkg::BOOT_LAST) ? disk_cmd_pkg::LEN_DD : disk_cmd_pkg::LEN_SD;
   assign fmt_len = dd ? disk_cmd_pkg::LEN_DD : disk_cmd_pkg::LEN_SD;

   always_comb begin
      case (q.cnt[1:0])
         2'h0: stat_byte = {3'h0, mech_rsp_i.motor, q.flags};
         2'h1: stat_byte = ~q.ctl;
         2'h2: stat_byte = q.fmt_tmo;
         default: stat_byte = 8'h00;
      endcase
   end

   always_comb begin
      tx_send = 1'b1;
      case (q.st)
         ST_SEND_ACK: tx_byte = disk_cmd_pkg::RSP_ACK;
         ST_DATA_ACK: tx_byte = disk_cmd_pkg::RSP_ACK;
         ST_SEND_NAK: tx_byte = disk_cmd_pkg::RSP_NAK;
         ST_SEND_FINAL: tx_byte = q.err ? disk_cmd_pkg::RSP_ERROR : disk_cmd_pkg::RSP_COMPLETE;
         ST_SEND_DATA: tx_byte = is_stat ? stat_byte : mem_rdata;
         ST_SEND_SUM: tx_byte = q.sum;
         default: begin
            tx_byte = 8'h00;
            tx_send = 1'b0;
         end
      endcase
   end

   // Bytes leave no faster than one serial byte time apart
   // A frozen block offers nothing, so the host cannot take a byte twice
   assign tx_valid = ce_i && tx_send && q.gap == 14'h0000;
   assign tx_fire = tx_valid && tx_ready_i;
   assign tx_o.valid = tx_valid;
   assign tx_o.data = tx_byte;
   assign mem_raddr = (q.st == ST_MECH) ? mech_buf_i.addr : q.cnt[7:0];
   assign mech_buf_rdata_o = mem_rdata;

   always_comb begin
      d = q;
      d.start = 1'b0;
      d.rdata = '0;
      ev = '0;
      wr_en = 1'b0;
      wr_addr = q.cnt[7:0];
      wr_data = rx_i.data;
      if (q.gap != 14'h0000) begin
         d.gap = q.gap - 14'h0001;
      end
      if (tx_fire) begin
         d.gap = 14'(TX_BYTE_CYCLES - 1);
      end
      case (q.st)
         ST_IDLE: begin
            // Collect a command frame while the command line is held
            if (!cmd_line_i) begin
               d.cnt = '0;
               d.sum = 8'h00;
            end else if (rx_i.valid) begin
               d.frm[q.cnt[2:0]] = rx_i.data;
               d.cnt = q.cnt + 9'h001;
               if (q.cnt != 9'h004) begin
                  d.sum = chk_add(q.sum, rx_i.data);
               end else begin
                  d.st = ST_CHECK;
                  d.cnt = '0;
               end
            end
         end
         ST_CHECK: begin
            d.sum = 8'h00;
            if (q.frm[0] != DEVICE_ID) begin
               d.st = ST_IDLE;
            end else if (q.sum != q.frm[4]) begin
               d.flags[disk_cmd_pkg::ST0_CMD] = 1'b1;
               ev[disk_cmd_pkg::IRQ_ABANDON] = 1'b1;
               d.st = ST_IDLE;
            end else begin
               d.flags[disk_cmd_pkg::ST0_CMD] = 1'b0;
               d.len = is_stat ? disk_cmd_pkg::LEN_STATUS : (is_fmt ? fmt_len : sect_len);
               if (known && (is_stat || is_fmt || sec_ok)) begin
                  d.st = ST_SEND_ACK;
               end else begin
                  d.st = ST_SEND_NAK;
               end
            end
         end
         ST_SEND_ACK: begin
            if (tx_fire) begin
               if (is_stat) begin
                  d.err = 1'b0;
                  d.st = ST_SEND_FINAL;
               end else if (is_put || is_write) begin
                  d.st = ST_RX_DATA;
               end else begin
                  d.st = ST_MECH;
                  d.start = 1'b1;
                  d.bptr = '0;
               end
            end
         end
         ST_SEND_NAK: begin
            if (tx_fire) begin
               ev[disk_cmd_pkg::IRQ_NAK] = 1'b1;
               d.st = ST_IDLE;
            end
         end
         ST_RX_DATA: begin
            if (rx_i.valid && !cmd_line_i) begin
               if (q.cnt < q.len) begin
                  wr_en = 1'b1;
                  d.sum = chk_add(q.sum, rx_i.data);
                  d.cnt = q.cnt + 9'h001;
               end else if (rx_i.data == q.sum) begin
                  d.flags[disk_cmd_pkg::ST0_DATA] = 1'b0;
                  d.st = ST_DATA_ACK;
               end else begin
                  d.flags[disk_cmd_pkg::ST0_DATA] = 1'b1;
                  if (q.ctrl[disk_cmd_pkg::CTRL_NAK_DATA_BIT]) begin
                     d.st = ST_SEND_NAK;
                  end else begin
                     ev[disk_cmd_pkg::IRQ_ABANDON] = 1'b1;
                     d.st = ST_IDLE;
                  end
               end
            end
         end
         ST_DATA_ACK: begin
            if (tx_fire) begin
               d.st = ST_MECH;
               d.start = 1'b1;
            end
         end
         ST_MECH: begin
            // Bad sector list is stored low byte first, one entry per two cycles
            if (q.bpend) begin
               wr_en = 1'b1;
               wr_addr = q.bptr[7:0] - 8'h01;
               wr_data = q.bhi;
               d.bpend = 1'b0;
            end else if (is_fmt && mech_rsp_i.bad_valid && q.bptr + 9'h004 <= q.len) begin
               wr_en = 1'b1;
               wr_addr = q.bptr[7:0];
               wr_data = mech_rsp_i.bad_sector[7:0];
               d.bhi = mech_rsp_i.bad_sector[15:8];
               d.bpend = 1'b1;
               d.bptr = q.bptr + 9'h002;
            end else if (is_read && mech_buf_i.we) begin
               wr_en = 1'b1;
               wr_addr = mech_buf_i.addr;
               wr_data = mech_buf_i.wdata;
            end
            if (mech_rsp_i.done) begin
               d.err = mech_rsp_i.error;
               d.ctl = mech_rsp_i.ctl_status;
               d.flags[disk_cmd_pkg::ST0_WP] = mech_rsp_i.wp_fail;
               d.flags[disk_cmd_pkg::ST0_PUT] = mech_rsp_i.error && (is_put || is_write);
               d.cnt = '0;
               d.st = is_fmt ? ST_FMT_TERM : ST_SEND_FINAL;
            end
         end
         ST_FMT_TERM: begin
            wr_en = 1'b1;
            if (q.bpend) begin
               wr_addr = q.bptr[7:0] - 8'h01;
               wr_data = q.bhi;
               d.bpend = 1'b0;
            end else begin
               wr_addr = q.bptr[7:0] + {7'h00, q.cnt[0]};
               wr_data = disk_cmd_pkg::FILL_FF;
               d.cnt = q.cnt + 9'h001;
               if (q.cnt[0]) begin
                  d.cnt = '0;
                  d.st = ST_SEND_FINAL;
               end
            end
         end
         ST_SEND_FINAL: begin
            if (tx_fire) begin
               ev[q.err ? disk_cmd_pkg::IRQ_ERROR : disk_cmd_pkg::IRQ_DONE] = 1'b1;
               d.cnt = '0;
               d.sum = 8'h00;
               d.st = (is_put || is_write) ? ST_IDLE : ST_SEND_DATA;
            end
         end
         ST_SEND_DATA: begin
            if (tx_fire) begin
               d.sum = chk_add(q.sum, tx_byte);
               d.cnt = q.cnt + 9'h001;
               if (q.cnt == q.len - 9'h001) begin
                  d.st = ST_SEND_SUM;
               end
            end
         end
         ST_SEND_SUM: begin
            if (tx_fire) begin
               d.cnt = '0;
               d.st = ST_IDLE;
            end
         end
         default: d.st = ST_IDLE;
      endcase

      if (reg_wr_i) begin
         case (reg_addr_i)
            disk_cmd_pkg::ADDR_CTRL: d.ctrl = reg_wdata_i[2:0];
            disk_cmd_pkg::ADDR_FMT_TMO: d.fmt_tmo = reg_wdata_i[7:0];
            disk_cmd_pkg::ADDR_IRQ_STAT: d.irq_st = q.irq_st & ~reg_wdata_i[3:0];
            disk_cmd_pkg::ADDR_IRQ_MASK: d.irq_mask = reg_wdata_i[3:0];
            default: d.ctrl = d.ctrl;
         endcase
      end
      // New events win over a clear in the same cycle
      d.irq_st = d.irq_st | ev;
      if (reg_rd_i) begin
         case (reg_addr_i)
            disk_cmd_pkg::ADDR_CTRL: d.rdata = {29'h0000_0000, q.ctrl};
            disk_cmd_pkg::ADDR_FMT_TMO: d.rdata = {24'h00_0000, q.fmt_tmo};
            disk_cmd_pkg::ADDR_IRQ_STAT: d.rdata = {28'h000_0000, q.irq_st};
            disk_cmd_pkg::ADDR_IRQ_MASK: d.rdata = {28'h000_0000, q.irq_mask};
            disk_cmd_pkg::ADDR_INFO: d.rdata = {23'h00_0000, q.st != ST_IDLE, q.frm[1]};
            default: d.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q <= '0;
         q.st <= ST_IDLE;
         q.ctrl <= disk_cmd_pkg::CTRL_RST;
         q.fmt_tmo <= disk_cmd_pkg::FMT_TMO_RST;
      end else if (ce_i) begin
         q <= d;
      end
   end

   sector_buffer u_buf (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .ce_i(ce_i),
      .we_i(wr_en),
      .waddr_i(wr_addr),
      .wdata_i(wr_data),
      .raddr_i(mem_raddr),
      .rdata_o(mem_rdata)
   );

   // Format zero fill and readback are carried out by the mechanism per op code
   assign mech_req_o.start = q.start;
   assign mech_req_o.op = is_fmt ? disk_cmd_pkg::MOP_FORMAT : (is_write ? disk_cmd_pkg::MOP_VERIFY :
                          (is_put ? disk_cmd_pkg::MOP_PUT : disk_cmd_pkg::MOP_READ));
   assign mech_req_o.sector = sec;
   assign mech_req_o.tracks = disk_cmd_pkg::FORMAT_TRACKS;
   assign reg_rdata_o = q.rdata;
   assign irq_o = |(q.irq_st & q.irq_mask);

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);

   AST_BAD_SECTOR_NAK: assert property (
      ce_i && q.st == ST_CHECK && q.frm[0] == DEVICE_ID && q.sum == q.frm[4] && (is_read || is_put) &&
      !dd && sec > disk_cmd_pkg::SD_MAX_SECTOR |=> q.st == ST_SEND_NAK)
      else $error("out of range sector not rejected");
   AST_NAK_ENDS: assert property (
      ce_i && tx_fire && q.st == ST_SEND_NAK |=> q.st == ST_IDLE && !tx_o.valid)
      else $error("negative acknowledge not final");
   AST_TX_PACE: assert property (
      ce_i && tx_fire |=> !tx_o.valid [*3])
      else $error("bytes sent too close together");
   AST_STATUS_LEN: assert property (
      q.st == ST_SEND_DATA && is_stat |-> q.len == disk_cmd_pkg::LEN_STATUS)
      else $error("status block length wrong");
   AST_STATUS_CTL: assert property (
      tx_o.valid && q.st == ST_SEND_DATA && is_stat && q.cnt == 9'h001 |-> tx_o.data == ~q.ctl)
      else $error("status byte one not inverted");
   AST_READ_DATA: assert property (
      ce_i && tx_fire && q.st == ST_SEND_FINAL && is_read |=> q.st == ST_SEND_DATA)
      else $error("read sent no data frame");
   AST_FINAL_CODE: assert property (
      tx_o.valid && q.st == ST_SEND_FINAL |-> tx_o.data == (q.err ? disk_cmd_pkg::RSP_ERROR :
                                                             disk_cmd_pkg::RSP_COMPLETE))
      else $error("final response code wrong");
   AST_BOOT_LEN: assert property (
      q.st == ST_SEND_DATA && is_read && sec <= disk_cmd_pkg::BOOT_LAST |-> q.len == disk_cmd_pkg::LEN_SD)
      else $error("boot sector frame not 128 bytes");
   AST_PUT_NO_DATA: assert property (
      ce_i && tx_fire && q.st == ST_SEND_FINAL && is_put |=> q.st == ST_IDLE)
      else $error("put answered with data frame");
   AST_BAD_DATA: assert property (
      ce_i && q.st == ST_RX_DATA && rx_i.valid && !cmd_line_i && q.cnt == q.len && rx_i.data != q.sum
      |=> q.st == ST_SEND_NAK || q.st == ST_IDLE)
      else $error("bad data frame accepted");
endmodule

// File: testbench/host_link_model.sv
`timescale 1ns/1ps
module host_link_model (
   // Clock
   input wire logic sys_clk_i,
   // Link towards the drive
   output logic cmd_line_o,
   output disk_cmd_pkg::byte_t rx_o,
   input disk_cmd_pkg::byte_t tx_i,
   output logic tx_ready_o
);
   logic [7:0] acc;
   logic slow;
   logic [7:0] q[$];

   function automatic logic [7:0] csum(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[7:0] + {7'h00, s[8]};
   endfunction

   initial begin
      cmd_line_o = 1'b0;
      rx_o = '0;
      tx_ready_o = 1'b0;
      slow = 1'b0;
   end

   // Every offered byte is captured; a slow host takes one every other cycle
   always @(posedge sys_clk_i) begin
      if (tx_i.valid && tx_ready_o) q.push_back(tx_i.data);
      tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
   end

   // Released data lines show the inverse of the last byte
   task automatic send(input logic [7:0] b);
      acc = csum(acc, b);
      @(posedge sys_clk_i);
      rx_o <= '{valid: 1'b1, data: b};
      @(posedge sys_clk_i);
      rx_o <= '{valid: 1'b0, data: ~b};
      repeat (2) @(posedge sys_clk_i);
   endtask

   task automatic frame(input logic [7:0] dev, input logic [7:0] c, input logic [15:0] s, input logic bad);
      acc = 8'h00;
      @(posedge sys_clk_i);
      cmd_line_o <= 1'b1;
      send(dev);
      send(c);
      send(s[7:0]);
      send(s[15:8]);
      send(acc ^ {7'h00, bad});
      cmd_line_o <= 1'b0;
   endtask

   // Called only once the command has been acknowledged
   task automatic data(input int n, input logic bad);
      acc = 8'h00;
      for (int i = 0; i < n; i++) send(i[7:0] ^ 8'h3C);
      send(acc ^ {7'h00, bad});
   endtask
endmodule

// File: testbench/disk_cmd_handler_tb.sv
`timescale 1ns/1ps
module disk_cmd_handler_tb;
   localparam logic [7:0] DEV = disk_cmd_pkg::DEVICE_ID_RST;
   logic clk, arst_n, cmd_line, tx_ready, irq, rwr, rrd;
   logic [7:0] raddr, mrd, sum;
   logic [31:0] rwdata, rrdata;
   disk_cmd_pkg::byte_t rx_b, tx_b;
   disk_cmd_pkg::mech_req_t mreq;
   disk_cmd_pkg::mech_rsp_t mrsp;
   disk_cmd_pkg::buf_port_t mbuf;
   int err_count, n_checks, cyc;

   disk_cmd_handler #(.TX_BYTE_CYCLES(8)) u_dut (
      .sys_clk_i(clk), .arst_n_i(arst_n), .ce_i(1'b1),
      .cmd_line_i(cmd_line), .rx_i(rx_b), .tx_o(tx_b), .tx_ready_i(tx_ready),
      .mech_req_o(mreq), .mech_rsp_i(mrsp), .mech_buf_i(mbuf), .mech_buf_rdata_o(mrd),
      .reg_addr_i(raddr), .reg_wdata_i(rwdata), .reg_wr_i(rwr), .reg_rd_i(rrd),
      .reg_rdata_o(rrdata), .irq_o(irq)
   );

   host_link_model h (
      .sys_clk_i(clk), .cmd_line_o(cmd_line), .rx_o(rx_b), .tx_i(tx_b), .tx_ready_o(tx_ready)
   );

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic test_done;
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Bounded wait stands in for the host's operation timeout
   task automatic rx(input logic [7:0] e, input logic chk);
      int n;
      n = 0;
      while (h.q.size() == 0 && n < 4000) begin
         @(negedge clk);
         n++;
      end
      if (n == 4000) check("reply", 32'h0, 32'h1);
      else if (chk) check("reply", h.q.pop_front(), e);
      else void'(h.q.pop_front());
      sum = h.csum(sum, e);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      raddr <= a;
      rwdata <= d;
      rwr <= 1'b1;
      @(posedge clk);
      rwr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      raddr <= a;
      rrd <= 1'b1;
      @(posedge clk);
      rrd <= 1'b0;
      @(negedge clk);
      check("register", rrdata, e);
   endtask

   // Mechanism: fills the buffer on reads, reports bad sectors on format
   task automatic mech(input logic [1:0] op, input logic [15:0] s, input logic e, input logic fill);
      int n;
      n = 0;
      while (mreq.start !== 1'b1 && n < 4000) begin
         @(negedge clk);
         n++;
      end
      check("op", mreq.op, op);
      check("sector", mreq.sector, s);
      if (op == disk_cmd_pkg::MOP_FORMAT) check("tracks", mreq.tracks, 6'h28);
      for (int i = 0; i < 128; i++) begin
         @(posedge clk);
         mbuf <= '{we: fill, addr: i[7:0], wdata: i[7:0] ^ 8'hA5};
         mrsp.bad_valid <= (op == disk_cmd_pkg::MOP_FORMAT) && (i == 10 || i == 20);
         mrsp.bad_sector <= {i[7:0], 8'h01};
      end
      @(posedge clk);
      mbuf <= '{we: 1'b0, addr: 8'h05, wdata: 8'h00};
      repeat (2) @(negedge clk);
      if (!fill) check("buffer", mrd, 8'h05 ^ 8'h3C);
      @(posedge clk);
      mrsp.done <= 1'b1;
      mrsp.error <= e;
      @(posedge clk);
      mrsp.done <= 1'b0;
   endtask

   task automatic t_reset;
      rd(disk_cmd_pkg::ADDR_CTRL, 32'h0000_0000);
      rd(disk_cmd_pkg::ADDR_FMT_TMO, 32'h0000_00E0);
      rd(disk_cmd_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
      wr(8'h20, 32'hFFFF_FFFF);
      rd(8'h20, 32'h0000_0000);
   endtask

   task automatic t_read;
      h.slow = 1'b1;
      h.frame(DEV, disk_cmd_pkg::CMD_READ, 16'h0001, 1'b0);
      rx(disk_cmd_pkg::RSP_ACK, 1'b1);
      mech(disk_cmd_pkg::MOP_READ, 16'h0001, 1'b1, 1'b1);
      rx(disk_cmd_pkg::RSP_ERROR, 1'b1);
      sum = 8'h00;
      for (int i = 0; i < 128; i++) rx(i[7:0] ^ 8'hA5, 1'b1);
      rx(sum, 1'b1);
      h.slow = 1'b0;
   endtask

   task automatic t_status;
      h.frame(DEV, disk_cmd_pkg::CMD_STATUS, 16'hBEEF, 1'b0);
      rx(disk_cmd_pkg::RSP_ACK, 1'b1);
      rx(disk_cmd_pkg::RSP_COMPLETE, 1'b1);
      sum = 8'h00;
      rx(8'h10, 1'b1);
      rx(8'hE7, 1'b1);
      rx(8'hE0, 1'b1);
      rx(8'h00, 1'b1);
      rx(sum, 1'b1);
   endtask

   task automatic t_nak;
      logic [7:0] cmds [3];
      cmds = '{disk_cmd_pkg::CMD_READ, disk_cmd_pkg::CMD_PUT, disk_cmd_pkg::CMD_WRITE};
      for (int c = 0; c < 6; c++) begin
         h.frame(DEV, cmds[c / 2], c[0] ? 16'h02D1 : 16'h0000, 1'b0);
         rx(disk_cmd_pkg::RSP_NAK, 1'b1);
      end
   endtask

   task automatic t_write;
      for (int w = 0; w < 2; w++) begin
         h.frame(DEV, w ? disk_cmd_pkg::CMD_WRITE : disk_cmd_pkg::CMD_PUT, 16'h02D0, 1'b0);
         rx(disk_cmd_pkg::RSP_ACK, 1'b1);
         h.data(128, 1'b0);
         rx(disk_cmd_pkg::RSP_ACK, 1'b1);
         mech(w ? disk_cmd_pkg::MOP_VERIFY : disk_cmd_pkg::MOP_PUT, 16'h02D0, w[0], 1'b0);
         rx(w ? disk_cmd_pkg::RSP_ERROR : disk_cmd_pkg::RSP_COMPLETE, 1'b1);
      end
   endtask

   task automatic t_abandon;
      wr(disk_cmd_pkg::ADDR_IRQ_STAT, 32'h0000_000F);
      h.frame(DEV, disk_cmd_pkg::CMD_STATUS, 16'h0000, 1'b1);
      h.frame(DEV, disk_cmd_pkg::CMD_PUT, 16'h0002, 1'b0);
      rx(disk_cmd_pkg::RSP_ACK, 1'b1);
      h.data(128, 1'b1);
      repeat (300) @(negedge clk);
      check("silence", h.q.size(), 32'h0);
      rd(disk_cmd_pkg::ADDR_IRQ_STAT, 32'h0000_0008);
      check("irq", irq, 1'b0);
      wr(disk_cmd_pkg::ADDR_IRQ_MASK, 32'h0000_0008);
      repeat (2) @(negedge clk);
      check("irq", irq, 1'b1);
      wr(disk_cmd_pkg::ADDR_IRQ_STAT, 32'h0000_0008);
      repeat (2) @(negedge clk);
      check("irq", irq, 1'b0);
   endtask

   task automatic t_format;
      // Host takes its format timeout from status byte two
      rd(disk_cmd_pkg::ADDR_FMT_TMO, 32'h0000_00E0);
      h.frame(DEV, disk_cmd_pkg::CMD_FORMAT, 16'h0000, 1'b0);
      rx(disk_cmd_pkg::RSP_ACK, 1'b1);
      mech(disk_cmd_pkg::MOP_FORMAT, 16'h0000, 1'b0, 1'b0);
      rx(disk_cmd_pkg::RSP_COMPLETE, 1'b1);
      rx(8'h01, 1'b1);
      rx(8'h0A, 1'b1);
      rx(8'h01, 1'b1);
      rx(8'h14, 1'b1);
      rx(8'hFF, 1'b1);
      rx(8'hFF, 1'b1);
      for (int i = 0; i < 123; i++) rx(8'h00, 1'b0);
   endtask

   // Double density, sector zero allowed, bad data frames answered with NAK
   task automatic t_dd;
      wr(disk_cmd_pkg::ADDR_CTRL, 32'h0000_0007);
      h.frame(DEV, disk_cmd_pkg::CMD_PUT, 16'h0000, 1'b0);
      rx(disk_cmd_pkg::RSP_ACK, 1'b1);
      h.data(128, 1'b1);
      rx(disk_cmd_pkg::RSP_NAK, 1'b1);
      h.frame(DEV, disk_cmd_pkg::CMD_READ, 16'h0400, 1'b0);
      rx(disk_cmd_pkg::RSP_ACK, 1'b1);
      mech(disk_cmd_pkg::MOP_READ, 16'h0400, 1'b0, 1'b1);
      rx(disk_cmd_pkg::RSP_COMPLETE, 1'b1);
      for (int i = 0; i < 257; i++) rx(i[7:0] ^ 8'hA5, i < 128);
      repeat (50) @(negedge clk);
      check("silence", h.q.size(), 32'h0);
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         test_done;
      end
   end

   initial begin
      {arst_n, rwr, rrd, raddr, rwdata, cyc, err_count, n_checks, sum} = '0;
      mrsp = '0;
      mrsp.motor = 1'b1;
      mrsp.ctl_status = 8'h18;
      mbuf = '0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      t_reset;
      t_read;
      t_status;
      t_nak;
      t_write;
      t_abandon;
      t_format;
      t_dd;
      test_done;
   end
endmodule
